// ===== hdl/ddrsq_pkg.sv
// constants, carriers and state codes shared by the memory power sequencer
package ddrsq_pkg;

  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'hC;

  // event bits of the status and mask registers
  localparam int unsigned EVT_W = 7;
  localparam int unsigned EVT_FAULT = 0;
  localparam int unsigned EVT_SHUT = 1;
  localparam int unsigned EVT_SUSPEND = 2;
  localparam int unsigned EVT_PGOOD = 3;
  localparam int unsigned EVT_OT_STANDBY = 4;
  localparam int unsigned EVT_OT_SOURCE = 5;
  localparam int unsigned EVT_OT_SINK = 6;
  localparam logic [EVT_W-1:0] MASK_RST = 7'h00;

  // state register layout
  localparam int unsigned STATE_CODE_LSB = 0;
  localparam int unsigned STATE_PGOOD_BIT = 4;
  localparam int unsigned STATE_FIRST_BIT = 5;
  localparam int unsigned STATE_RAILS_LSB = 8;

  // control register: soft-start duty steps once every ramp_step + 1 cycles
  localparam int unsigned RAMP_W = 8;
  localparam logic [RAMP_W-1:0] RAMP_STEP_RST = 8'h10;

  // synchroniser depth for the sleep inputs
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    S_OFF,
    S_RUN,
    S_S3,
    S_EXIT,
    S_SHUT,
    S_FAULT
  } ddrsq_state_t;

  // comparator flags, already synchronous and debounced
  typedef struct packed {
    logic logic_supply_5v_ok;
    logic gate_supply_12v_ok;
    logic ss_above_0v3;
    logic ss_above_0v8;
    logic ss_above_1v0;
    logic ss_above_1v25;
    logic rail_feedback_low;
    logic ot_standby;
    logic ot_tt_source;
    logic ot_tt_sink;
    logic pwm_on;
  } ddrsq_cmp_t;

  // rail enables
  typedef struct packed {
    logic switcher_en;
    logic standby_memory_rail_en;
    logic tt_source_en;
    logic tt_sink_en;
    logic tt_hiz;
  } ddrsq_rails_t;

endpackage : ddrsq_pkg

// ===== hdl/ddrsq_sequencer.sv
// sleep-state sequencing and protection logic of the memory power controller
// What this block does
// [RULE1] In suspend the memory rail is fed from the standby supply able to give 650 mA.
// [RULE2] The termination rail is high impedance for the whole suspend state.
// [RULE3] When suspend input returns high the switcher restarts and takes the rail back.
// [RULE4] With both sleep inputs low every supply, standby and termination included, is off.
// [RULE5] After full shutdown the block stays off until soft-start drops below 0.3V and rises.
// [RULE6] The switcher starts asynchronous, high-side gate only, once soft-start exceeds 0.3V.
// [RULE7] The soft-start node may rise only when both 5 V and 12 V supplies pass lockout.
// [RULE8] Permitted duty ramps with soft-start and is at maximum from 0.8V.
// [RULE9] The low-side gate runs only from 1.25V soft-start, ending asynchronous mode.
// [RULE10] The first power-up always passes through the active state on the switcher.
// [RULE11] Leaving suspend keeps standby on until soft-start reaches 1V, then power good rises.
// [RULE12] The chipset holds both sleep inputs at defined levels before power is applied.
// [RULE13] The low-side gate stops as soon as suspend input falls.
// [RULE14] Feedback at 75% of nominal latches both gates and all regulators off.
// [RULE15] The feedback fault latch clears only on supply cycling or a soft-start pull-low.
// [RULE16] Three thermal trips each disable only their own regulator while hot.
// [RULE17] Analog thresholds arrive as synchronous debounced comparator flags.
`timescale 1ns/1ps
`default_nettype none

module ddrsq_sequencer
  import ddrsq_pkg::*;
#(
  parameter int unsigned DUTY_W = 6
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // sleep inputs from the chipset, asynchronous
  input wire logic suspend_sleep_in_i,
  input wire logic softoff_sleep_in_i,
  // analog comparator flags
  input wire ddrsq_cmp_t cmp_i,
  // gate drives and rail controls
  output logic high_side_gate_drive_o,
  output logic low_side_gate_drive_o,
  output ddrsq_rails_t rails_o,
  output logic ss_pulldown_o,
  output logic power_good_o,
  output logic [DUTY_W-1:0] duty_limit_o,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic irq_o
);

  typedef struct packed {
    ddrsq_state_t state;
    logic [SYNC_STAGES-1:0] s3_sync;
    logic [SYNC_STAGES-1:0] s5_sync;
    logic s3_ok;
    logic s5_ok;
    logic first_done;
    logic power_good;
    logic [DUTY_W-1:0] duty;
    logic [RAMP_W-1:0] ramp_cnt;
    logic [RAMP_W-1:0] ramp_step;
    logic [DUTY_W-1:0] pwm_cnt;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic [2:0] ot_prev;
    logic hs;
    logic ls;
    logic ss_pd;
    ddrsq_rails_t rails;
    logic [DATA_W-1:0] rdata;
  } ddrsq_regs_t;

  localparam logic [DUTY_W-1:0] DUTY_MAX = {DUTY_W{1'b1}};

  ddrsq_regs_t r_reg;
  ddrsq_regs_t r_next;
  logic uvlo_ok;
  logic sw_on;
  logic [EVT_W-1:0] evt;
  logic [2:0] ot_now;

  assign uvlo_ok = cmp_i.logic_supply_5v_ok & cmp_i.gate_supply_12v_ok;
  assign ot_now = {cmp_i.ot_tt_sink, cmp_i.ot_tt_source, cmp_i.ot_standby};

  always_comb begin
    r_next = r_reg;
    evt = '0;

    // sleep inputs: the first stage feeds only the second; a level counts once
    // stages two and three agree, which also filters a glitch on the pins
    r_next.s3_sync = {r_reg.s3_sync[SYNC_STAGES-2:0], suspend_sleep_in_i};
    r_next.s5_sync = {r_reg.s5_sync[SYNC_STAGES-2:0], softoff_sleep_in_i};
    if (r_reg.s3_sync[1] == r_reg.s3_sync[2]) begin
      r_next.s3_ok = r_reg.s3_sync[1]; // RULE12
    end
    if (r_reg.s5_sync[1] == r_reg.s5_sync[2]) begin
      r_next.s5_ok = r_reg.s5_sync[1];
    end

    // sleep-state sequencing
    case (r_reg.state)
      S_OFF: begin
        r_next.power_good = 1'b0;
        if (r_next.s3_ok && r_next.s5_ok && uvlo_ok && cmp_i.ss_above_0v3) begin
          r_next.state = S_RUN; // RULE10
          r_next.first_done = 1'b1;
        end else if (r_reg.first_done && !r_next.s3_ok && r_next.s5_ok) begin
          r_next.state = S_S3; // RULE10
        end
      end
      S_RUN: begin
        if (!r_next.s3_ok && !r_next.s5_ok) begin
          r_next.state = S_SHUT; // RULE4
        end else if (!r_next.s3_ok) begin
          r_next.state = S_S3;
        end else if (r_reg.power_good && cmp_i.rail_feedback_low) begin
          r_next.state = S_FAULT; // RULE14
        end else if (!uvlo_ok) begin
          r_next.state = S_OFF;
        end
      end
      S_S3: begin
        if (!r_next.s5_ok) begin
          r_next.state = S_SHUT; // RULE4
        end else if (r_next.s3_ok) begin
          r_next.state = S_EXIT; // RULE3
        end
      end
      S_EXIT: begin
        if (!r_next.s5_ok) begin
          r_next.state = S_SHUT;
        end else if (!r_next.s3_ok) begin
          r_next.state = S_S3;
        end else if (uvlo_ok && cmp_i.ss_above_1v0) begin
          r_next.state = S_RUN; // RULE11
        end
      end
      S_SHUT: begin
        // stays dark until the soft-start node is seen low; a supply drop pulls it low too
        if (!cmp_i.ss_above_0v3) begin
          r_next.state = S_OFF; // RULE5
          r_next.first_done = 1'b0;
        end
      end
      S_FAULT: begin
        if (!cmp_i.ss_above_0v3 || !uvlo_ok) begin
          r_next.state = S_OFF; // RULE15
        end
      end
      default: begin
        r_next.state = S_OFF;
      end
    endcase

    // power good only once the switcher alone carries the rail
    if (r_next.state == S_RUN) begin
      r_next.power_good = cmp_i.ss_above_1v0; // RULE11
    end else begin
      r_next.power_good = 1'b0;
    end

    // soft-start duty ramp; the step is software-set
    if (!cmp_i.ss_above_0v3) begin
      r_next.duty = '0;
      r_next.ramp_cnt = '0;
    end else if (cmp_i.ss_above_0v8) begin
      r_next.duty = DUTY_MAX; // RULE8
    end else if (r_reg.ramp_cnt >= r_reg.ramp_step) begin
      r_next.ramp_cnt = '0;
      if (r_reg.duty != DUTY_MAX) begin
        r_next.duty = r_reg.duty + 1'b1; // RULE8
      end
    end else begin
      r_next.ramp_cnt = r_reg.ramp_cnt + 1'b1;
    end
    r_next.pwm_cnt = r_reg.pwm_cnt + 1'b1;

    // gate drives follow the next state, so a fault or suspend cuts them at once
    sw_on = (r_next.state == S_RUN || r_next.state == S_EXIT) && uvlo_ok && cmp_i.ss_above_0v3;
    r_next.hs = sw_on && cmp_i.pwm_on && (r_reg.pwm_cnt < r_next.duty); // RULE6
    r_next.ls = sw_on && cmp_i.ss_above_1v25 && !r_next.hs && r_next.s3_ok; // RULE9 RULE13

    // rails; each thermal trip gates only its own regulator
    r_next.rails.switcher_en = (r_next.state == S_RUN || r_next.state == S_EXIT);
    r_next.rails.standby_memory_rail_en =
      (r_next.state == S_S3 || r_next.state == S_EXIT) && !cmp_i.ot_standby; // RULE1 RULE11 RULE16
    r_next.rails.tt_source_en = r_next.rails.switcher_en && !cmp_i.ot_tt_source; // RULE16
    r_next.rails.tt_sink_en = r_next.rails.switcher_en && !cmp_i.ot_tt_sink; // RULE16
    r_next.rails.tt_hiz = !r_next.rails.switcher_en; // RULE2 RULE4

    // soft-start held low while either supply is under lockout
    r_next.ss_pd = !uvlo_ok; // RULE7 RULE17

    // events
    evt[EVT_FAULT] = (r_next.state == S_FAULT) && (r_reg.state != S_FAULT);
    evt[EVT_SHUT] = (r_next.state == S_SHUT) && (r_reg.state != S_SHUT);
    evt[EVT_SUSPEND] = (r_next.state == S_S3) && (r_reg.state != S_S3);
    evt[EVT_PGOOD] = r_next.power_good && !r_reg.power_good;
    evt[EVT_OT_SINK:EVT_OT_STANDBY] = ot_now & ~r_reg.ot_prev;
    r_next.ot_prev = ot_now;

    // register port; a read of status clears it, but a new event wins
    r_next.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        REG_STATUS: r_next.rdata[EVT_W-1:0] = r_reg.status;
        REG_MASK: r_next.rdata[EVT_W-1:0] = r_reg.mask;
        REG_STATE: begin
          r_next.rdata[STATE_CODE_LSB +: 3] = r_reg.state;
          r_next.rdata[STATE_PGOOD_BIT] = r_reg.power_good;
          r_next.rdata[STATE_FIRST_BIT] = r_reg.first_done;
          r_next.rdata[STATE_RAILS_LSB +: 5] = r_reg.rails;
        end
        REG_CTRL: r_next.rdata[RAMP_W-1:0] = r_reg.ramp_step;
        default: r_next.rdata = '0;
      endcase
    end
    if (rd_i && addr_i == REG_STATUS) begin
      r_next.status = evt;
    end else begin
      r_next.status = r_reg.status | evt;
    end
    if (wr_i && addr_i == REG_MASK) begin
      r_next.mask = wdata_i[EVT_W-1:0];
    end
    if (wr_i && addr_i == REG_CTRL) begin
      r_next.ramp_step = wdata_i[RAMP_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r_reg <= '{
        state: S_OFF,
        ramp_step: RAMP_STEP_RST,
        mask: MASK_RST,
        rails: '{tt_hiz: 1'b1, default: 1'b0},
        ss_pd: 1'b1,
        default: '0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  assign high_side_gate_drive_o = r_reg.hs;
  assign low_side_gate_drive_o = r_reg.ls;
  assign rails_o = r_reg.rails;
  assign ss_pulldown_o = r_reg.ss_pd;
  assign power_good_o = r_reg.power_good;
  assign duty_limit_o = r_reg.duty;
  assign rdata_o = r_reg.rdata;
  assign irq_o = |(r_reg.status & r_reg.mask);

  // checks
  property p_standby_in_s3;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_S3) && !$past(cmp_i.ot_standby) |-> rails_o.standby_memory_rail_en;
  endproperty
  a_standby_in_s3: assert property (p_standby_in_s3) // RULE1
    else $error("standby rail off in suspend");

  property p_hiz_in_s3;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_S3) |-> rails_o.tt_hiz && !rails_o.tt_source_en && !rails_o.tt_sink_en;
  endproperty
  a_hiz_in_s3: assert property (p_hiz_in_s3) // RULE2
    else $error("termination rail driven in suspend");

  property p_resume;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_S3) && r_next.s3_ok && r_next.s5_ok |=> (r_reg.state == S_EXIT);
  endproperty
  a_resume: assert property (p_resume) // RULE3
    else $error("suspend exit did not restart the switcher");

  property p_shut_all_off;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_SHUT) |-> !rails_o.switcher_en && !rails_o.standby_memory_rail_en
      && !rails_o.tt_source_en && !rails_o.tt_sink_en && !high_side_gate_drive_o;
  endproperty
  a_shut_all_off: assert property (p_shut_all_off) // RULE4
    else $error("supply left on in soft-off");

  property p_shut_holds;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_SHUT) && cmp_i.ss_above_0v3 |=> (r_reg.state == S_SHUT);
  endproperty
  a_shut_holds: assert property (p_shut_holds) // RULE5
    else $error("left shutdown without soft-start pull-low");

  property p_async_start;
    @(posedge core_clk_i) disable iff (reset_i)
    high_side_gate_drive_o |-> $past(cmp_i.ss_above_0v3) && $past(uvlo_ok);
  endproperty
  a_async_start: assert property (p_async_start) // RULE6
    else $error("high-side gate before soft-start threshold");

  property p_ss_hold;
    @(posedge core_clk_i) disable iff (reset_i)
    !uvlo_ok |=> ss_pulldown_o;
  endproperty
  a_ss_hold: assert property (p_ss_hold) // RULE7
    else $error("soft-start released under lockout");

  property p_duty_max;
    @(posedge core_clk_i) disable iff (reset_i)
    cmp_i.ss_above_0v3 && cmp_i.ss_above_0v8 |=> (duty_limit_o == DUTY_MAX);
  endproperty
  a_duty_max: assert property (p_duty_max) // RULE8
    else $error("duty not at maximum above 0.8V");

  property p_duty_ramp;
    @(posedge core_clk_i) disable iff (reset_i)
    cmp_i.ss_above_0v3 && !cmp_i.ss_above_0v8 && (duty_limit_o != DUTY_MAX)
      |=> (duty_limit_o == $past(duty_limit_o)) || (duty_limit_o == $past(duty_limit_o) + 1'b1);
  endproperty
  a_duty_ramp: assert property (p_duty_ramp) // RULE8
    else $error("duty stepped by more than one");

  property p_sync_gate;
    @(posedge core_clk_i) disable iff (reset_i)
    low_side_gate_drive_o |-> $past(cmp_i.ss_above_1v25) && !high_side_gate_drive_o;
  endproperty
  a_sync_gate: assert property (p_sync_gate) // RULE9
    else $error("low-side gate below 1.25V");

  property p_first_s0;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_S3) |-> r_reg.first_done;
  endproperty
  a_first_s0: assert property (p_first_s0) // RULE10
    else $error("suspend before first active pass");

  property p_pgood;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(power_good_o) |-> $past(cmp_i.ss_above_1v0) && (r_reg.state == S_RUN);
  endproperty
  a_pgood: assert property (p_pgood) // RULE11
    else $error("power good before 1V");

  property p_bg_stop;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(r_reg.s3_ok) |-> !low_side_gate_drive_o;
  endproperty
  a_bg_stop: assert property (p_bg_stop) // RULE13
    else $error("low-side gate still switching in suspend");

  property p_fault_off;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_FAULT) |-> !high_side_gate_drive_o && !low_side_gate_drive_o
      && !rails_o.switcher_en && !rails_o.standby_memory_rail_en;
  endproperty
  a_fault_off: assert property (p_fault_off) // RULE14
    else $error("drive on while latched off");

  property p_fault_latch;
    @(posedge core_clk_i) disable iff (reset_i)
    (r_reg.state == S_FAULT) && cmp_i.ss_above_0v3 && uvlo_ok |=> (r_reg.state == S_FAULT);
  endproperty
  a_fault_latch: assert property (p_fault_latch) // RULE15
    else $error("fault latch cleared without restart");

  property p_ot_sink;
    @(posedge core_clk_i) disable iff (reset_i)
    cmp_i.ot_tt_sink |=> !rails_o.tt_sink_en;
  endproperty
  a_ot_sink: assert property (p_ot_sink) // RULE16
    else $error("sink regulator on while hot");

endmodule : ddrsq_sequencer

`default_nettype wire

// ===== bench/ddrsq_chipset_model.sv
// chipset model that drives the two sleep-state lines of the memory sequencer
`timescale 1ns/1ps
`default_nettype none

module ddrsq_chipset_model (
  // clock
  input wire logic core_clk_i,
  // wanted state (0 active, 1 suspend, 2 soft-off) and answer delay in cycles
  input wire logic [1:0] target_i,
  input wire logic [3:0] lag_i,
  // sleep lines
  output logic suspend_sleep_in_o,
  output logic softoff_sleep_in_o
);
  // lines start high at time zero, as if pulled up, so they are never undefined
  logic [1:0] cur_reg = 2'h0;
  logic [3:0] cnt_reg = 4'h0;

  always @(posedge core_clk_i) begin
    if (target_i == cur_reg) begin
      cnt_reg <= lag_i;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      cur_reg <= target_i;
    end
  end

  assign suspend_sleep_in_o = (cur_reg == 2'h0);
  assign softoff_sleep_in_o = (cur_reg != 2'h2);
endmodule : ddrsq_chipset_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the memory power sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench
  import ddrsq_pkg::*;
;
  localparam logic [4:0] RUN = 5'h16;
  localparam logic [4:0] S3 = 5'h09;
  localparam logic [4:0] OFF = 5'h01;
  localparam logic [9:0] F_SUP = 10'h300;
  localparam logic [9:0] F_SS = 10'h0C0;
  localparam logic [9:0] F_S03 = 10'h080;
  localparam logic [9:0] F_10 = 10'h020;
  localparam logic [9:0] F_125 = 10'h010;
  localparam logic [9:0] F_FB = 10'h008;
  localparam logic [9:0] F_OTSB = 10'h004;

  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] cmp_f = '0;
  logic pwm = 1'b0;
  logic [9:0] fl = '0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [1:0] target = 2'h0;
  logic [3:0] lag = 4'h0;
  logic suspend_sleep_in, softoff_sleep_in, hs, ls, pdn, pgood, irq;
  logic hs_any, ls_any, both_any;
  ddrsq_rails_t rails;
  logic [5:0] duty;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] exp_q[$];
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h1dc3;

  always #2 core_clk_i = ~core_clk_i;

  ddrsq_chipset_model i_ddrsq_chipset_model (.core_clk_i(core_clk_i), .target_i(target),
    .lag_i(lag), .suspend_sleep_in_o(suspend_sleep_in), .softoff_sleep_in_o(softoff_sleep_in));

  ddrsq_sequencer #(.DUTY_W(6)) i_ddrsq_sequencer (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .suspend_sleep_in_i(suspend_sleep_in),
    .softoff_sleep_in_i(softoff_sleep_in), .cmp_i(ddrsq_cmp_t'({cmp_f, pwm})),
    .high_side_gate_drive_o(hs),
    .low_side_gate_drive_o(ls), .rails_o(rails), .ss_pulldown_o(pdn), .power_good_o(pgood),
    .duty_limit_o(duty), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq));

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t output %0h expected %0h", $time, got, exp);
    end
  endtask : chk_sig

  task automatic chk_rd(input logic [31:0] exp);
    n_compared++;
    if (rdata !== exp) begin
      bad_count++;
      $display("[ERR] %0t read %0h expected %0h", $time, rdata, exp);
    end
  endtask : chk_rd

  // read data stands only in the cycle after the strobe, so look mid-cycle
  always @(negedge core_clk_i) begin
    if (rd_seen) begin
      chk_rd(exp_q.pop_front());
    end
  end

  always @(posedge core_clk_i) begin
    rd_seen <= rd;
    pwm <= 1'($random(seed));
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic flags(input logic [9:0] f);
    @(posedge core_clk_i);
    fl = f;
    cmp_f <= f;
  endtask : flags

  task automatic sleep(input logic [1:0] t, input logic [3:0] l);
    @(posedge core_clk_i);
    target <= t;
    lag <= l;
  endtask : sleep

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge core_clk_i);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    rd <= 1'b0;
  endtask : reg_rd

  // sequencing is slow through the sleep synchroniser, so allow a bounded wait
  task automatic wait_rails(input logic [4:0] e, input logic [4:0] m);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while ((rails & m) !== e && n < 40) begin
      @(negedge core_clk_i);
      n++;
    end
    chk_sig(rails & m, e);
  endtask : wait_rails

  task automatic watch(input int n);
    hs_any = 1'b0;
    ls_any = 1'b0;
    both_any = 1'b0;
    repeat (n) begin
      @(negedge core_clk_i);
      hs_any = hs_any | hs;
      ls_any = ls_any | ls;
      both_any = both_any | (hs & ls);
    end
  endtask : watch

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(negedge core_clk_i);
    chk_sig(pdn, 1'b1);
    reg_rd(REG_MASK, 32'h0);
    reg_rd(4'h2, 32'h0);
    reg_rd(REG_CTRL, 32'h10);
    reg_wr(REG_CTRL, 32'h1);
    reg_rd(REG_CTRL, 32'h1);
    reg_wr(REG_MASK, 32'h7F);
    flags(F_SUP);
    repeat (3) @(negedge core_clk_i);
    chk_sig(pdn, 1'b0);
    flags(F_SUP | F_S03);
    wait_rails(RUN, 5'h1F);
    repeat (20) @(negedge core_clk_i);
    chk_sig((duty != 6'h00) && (duty != 6'h3F), 1'b1);
    flags(F_SUP | F_SS);
    watch(100);
    chk_sig(ls_any, 1'b0);
    chk_sig(hs_any, 1'b1);
    chk_sig(duty, 6'h3F);
    flags(fl | F_10);
    repeat (2) @(negedge core_clk_i);
    chk_sig(pgood, 1'b1);
    reg_wr(REG_STATE, 32'h0);
    reg_rd(REG_STATE, 32'h1631);
    @(negedge core_clk_i);
    chk_sig(irq, 1'b1);
    reg_rd(REG_STATUS, 32'h8);
    @(negedge core_clk_i);
    chk_sig(irq, 1'b0);
    flags(fl | F_125);
    watch(100);
    chk_sig(ls_any, 1'b1);
    chk_sig(both_any, 1'b0);
    sleep(2'h1, 4'h0);
    wait_rails(S3, 5'h1F);
    watch(20);
    chk_sig(ls_any, 1'b0);
    flags(fl | F_OTSB);
    wait_rails(OFF, 5'h1F);
    flags(fl & ~F_OTSB);
    wait_rails(S3, 5'h1F);
    reg_rd(REG_STATUS, 32'h14);
    flags(F_SUP | F_SS);
    sleep(2'h0, 4'h6);
    wait_rails(5'h10, 5'h10);
    chk_sig(pgood, 1'b0);
    repeat (10) @(negedge core_clk_i);
    chk_sig(rails.standby_memory_rail_en, 1'b1);
    flags(fl | F_10 | F_125);
    wait_rails(RUN, 5'h1F);
    chk_sig(pgood, 1'b1);
    reg_wr(REG_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      flags(fl | (10'h001 << i));
      wait_rails(RUN & ~(5'h02 << i), 5'h1F);
      chk_sig(irq, 1'b0);
      flags(fl & ~(10'h001 << i));
      wait_rails(RUN, 5'h1F);
    end
    reg_rd(REG_STATUS, 32'h68);
    flags(fl | F_FB);
    wait_rails(OFF, 5'h1F);
    watch(10);
    chk_sig(hs_any | ls_any, 1'b0);
    chk_sig(irq, 1'b1);
    flags(fl & ~F_FB);
    watch(20);
    chk_sig(rails, OFF);
    reg_rd(REG_STATUS, 32'h1);
    flags(F_SUP);
    repeat (3) @(posedge core_clk_i);
    flags(F_SUP | F_SS | F_10 | F_125);
    wait_rails(RUN, 5'h1F);
    sleep(2'h2, 4'h0);
    wait_rails(OFF, 5'h1F);
    sleep(2'h0, 4'h0);
    repeat (20) @(negedge core_clk_i);
    chk_sig(rails, OFF);
    reg_rd(REG_STATUS, 32'hA);
    flags(F_SUP);
    repeat (3) @(posedge core_clk_i);
    flags(F_SUP | F_SS | F_10);
    wait_rails(RUN, 5'h1F);
    final_report();
  end
endmodule : testbench
`default_nettype wire
